// ### hdl/debug_tap_controller.sv
// Purpose: test access port controller for a processor debug port
// Assumes: pins arrive asynchronously and are synchronised here; chains are outside
// Notes: no separate test clock; every step is qualified by the enable pin
//
// Contract
// - advance only on enabled rising clock edges
// - test reset forces cells into system mode
// - reset makes identification the current instruction
// - unknown instruction codes act as bypass
// - chain select routes select register, captures 1000
// - update-dr connects shifted chain, holds it
// - reset selects scan chain zero
// - scan path select register is four bits
// - internal test connects chain, cells test mode
// - internal test capture strobes the chain
// - internal test shift moves chain data
// - identification captures fixed code, shifts out
// - identification update changes nothing
// - bypass register captures zero
// - bypass delays serial data one enabled clock
// - bypass keeps system mode, no update
// - debug resume routes like bypass
// - debug resume signals exit on idle entry
// - four-bit ir captures 0001, shifts lsb first
// - reserved chains shift out only zeros

`timescale 1ns/1ns
`default_nettype none

module debug_tap_controller
  import tap_pkg::*;
#(
  parameter logic [ID_W-1:0] IDENT_CODE = 32'h1234_5679  // arbitrary value
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic mode_select_in_i,
  input wire logic serial_in_i,
  input wire logic tap_clock_enable_i,
  input wire logic test_reset_n_i,
  input wire logic [CHAIN_CNT-1:0] chain_return_i,
  output logic serial_out_o,
  output scan_ctrl_s scan_o,
  output logic debug_restart_o
);

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic [SYNC_W-1:0] pins_raw;   // raw pin levels
  logic [SYNC_W-1:0] pins_f;     // filtered, synchronised levels
  assign pins_raw[PIN_MODE] = mode_select_in_i;
  assign pins_raw[PIN_DATA] = serial_in_i;
  assign pins_raw[PIN_ENABLE] = tap_clock_enable_i;
  assign pins_raw[PIN_TRST] = test_reset_n_i;

  // three synchroniser flops and a filter flop per pin; a change counts once stages two and three agree
  for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
    logic s1;
    logic s2;
    logic s3;
    logic f;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        s1 <= PIN_RESET_VAL[g];
        s2 <= PIN_RESET_VAL[g];
        s3 <= PIN_RESET_VAL[g];
        f <= PIN_RESET_VAL[g];
      end else begin
        s1 <= pins_raw[g];
        s2 <= s1;
        s3 <= s2;
        // only stages two and three feed the filter
        if (s2 == s3) begin
          f <= s3;
        end
      end
    end
    assign pins_f[g] = f;
  end

  logic tms;      // mode select
  logic tdi;      // serial data in
  logic en;       // shift/advance qualifier
  logic trst_n;   // test reset, active low
  assign tms = pins_f[PIN_MODE];
  assign tdi = pins_f[PIN_DATA];
  assign en = pins_f[PIN_ENABLE];
  assign trst_n = pins_f[PIN_TRST];

  // ---------------------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------------------
  tap_state_e state;        // current tap state
  tap_state_e next_state;   // graph successor for the sampled mode bit
  // standard transition graph
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  // state register; test reset wins over any step
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_RESET;
    end else if (!trst_n) begin
      state <= ST_RESET;
    end else if (en) begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------------
  // instruction register
  // ---------------------------------------------------------------------------
  logic [IR_W-1:0] ir_shift;   // serial stage
  logic [IR_W-1:0] instr;      // current instruction
  // capture, shift lsb first, update
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ir_shift <= IR_CAPTURE_VAL;
      instr <= IDENT_INSTR;
    end else if (!trst_n || (en && next_state == ST_RESET)) begin
      ir_shift <= IR_CAPTURE_VAL;
      instr <= IDENT_INSTR;
    end else if (en) begin
      unique case (state)
        ST_CAP_IR: ir_shift <= IR_CAPTURE_VAL;
        ST_SHIFT_IR: ir_shift <= {tdi, ir_shift[IR_W-1:1]};
        ST_UPD_IR: instr <= ir_shift;
        default: ir_shift <= ir_shift;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------------------
  dr_path_e dr_sel;   // data register on the serial path
  always_comb begin
    unique case (instr)
      CHAIN_SELECT_INSTR: dr_sel = DR_CHAIN_SEL;
      INTERNAL_TEST_INSTR: dr_sel = DR_INTERNAL;
      IDENT_INSTR: dr_sel = DR_IDENT;
      default: dr_sel = DR_BYPASS;
    endcase
  end

  logic cap_dr;     // enabled capture-dr step
  logic shift_dr;   // enabled shift-dr step
  logic upd_dr;     // enabled update-dr step
  assign cap_dr = en && trst_n && state == ST_CAP_DR;
  assign shift_dr = en && trst_n && state == ST_SHIFT_DR;
  assign upd_dr = en && trst_n && state == ST_UPD_DR;

  // ---------------------------------------------------------------------------
  // data registers
  // ---------------------------------------------------------------------------
  logic [SEL_W-1:0] sel_shift;   // scan path select register
  logic [SEL_W-1:0] chain;       // active scan chain
  logic [ID_W-1:0] id_shift;     // identification register
  logic bypass;                  // bypass register

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_shift <= SEL_CAPTURE_VAL;
    end else if (dr_sel == DR_CHAIN_SEL) begin
      if (cap_dr) begin
        sel_shift <= SEL_CAPTURE_VAL;
      end else if (shift_dr) begin
        sel_shift <= {tdi, sel_shift[SEL_W-1:1]};
      end
    end
  end

  // active chain: reset to zero, changed only by a chain select update
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      chain <= CHAIN_RESET_VAL;
    end else if (!trst_n) begin
      chain <= CHAIN_RESET_VAL;
    end else if (upd_dr && dr_sel == DR_CHAIN_SEL) begin
      chain <= sel_shift;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      id_shift <= IDENT_CODE;
    end else if (dr_sel == DR_IDENT) begin
      if (cap_dr) begin
        id_shift <= IDENT_CODE;
      end else if (shift_dr) begin
        id_shift <= {tdi, id_shift[ID_W-1:1]};
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bypass <= 1'b0;
    end else if (dr_sel == DR_BYPASS) begin
      if (cap_dr) begin
        bypass <= 1'b0;
      end else if (shift_dr) begin
        bypass <= tdi;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // external scan chain control
  // ---------------------------------------------------------------------------
  logic chain_bit;   // serial return of the active chain
  logic intest;      // internal test current and not in test reset
  always_comb begin
    unique case (chain)
      CHAIN_USER: chain_bit = chain_return_i[0];
      CHAIN_DEBUG: chain_bit = chain_return_i[1];
      CHAIN_ICE: chain_bit = chain_return_i[2];
      CHAIN_SYSCTL: chain_bit = chain_return_i[3];
      default: chain_bit = 1'b0;
    endcase
  end

  assign intest = trst_n && dr_sel == DR_INTERNAL;

  // strobes toward the chains
  always_comb begin
    scan_o.chain = chain;
    scan_o.test_mode = intest;
    scan_o.capture = intest && cap_dr;
    scan_o.shift = intest && shift_dr;
    scan_o.update = intest && upd_dr;
    scan_o.serial_data = tdi;
  end

  // ---------------------------------------------------------------------------
  // serial output
  // ---------------------------------------------------------------------------
  logic next_serial_out;   // lsb of the register on the path
  always_comb begin
    next_serial_out = 1'b0;
    if (state == ST_SHIFT_IR) begin
      next_serial_out = ir_shift[0];
    end else if (state == ST_SHIFT_DR) begin
      unique case (dr_sel)
        DR_BYPASS: next_serial_out = bypass;
        DR_IDENT: next_serial_out = id_shift[0];
        DR_CHAIN_SEL: next_serial_out = sel_shift[0];
        DR_INTERNAL: next_serial_out = chain_bit;
      endcase
    end
  end

  // registered serial output
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      serial_out_o <= 1'b0;
    end else begin
      serial_out_o <= next_serial_out;
    end
  end

  // ---------------------------------------------------------------------------
  // debug resume
  // ---------------------------------------------------------------------------
  // pulse on idle entry
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      debug_restart_o <= 1'b0;
    end else begin
      // update-ir makes the shifted code current as idle is entered
      debug_restart_o <= en && trst_n && state != ST_IDLE && next_state == ST_IDLE &&
                         (state == ST_UPD_IR ? ir_shift : instr) == DEBUG_RESUME_INSTR;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  a_step_needs_enable: assert property (
    trst_n && !en |=> $stable(state) && $stable(ir_shift) && $stable(id_shift))
    else $error("tap moved without enable");
  a_trst_system_mode: assert property (
    !trst_n |=> state == ST_RESET && !scan_o.test_mode && instr == IDENT_INSTR)
    else $error("test reset did not restore system mode");
  a_unknown_bypass: assert property (
    instr != CHAIN_SELECT_INSTR && instr != INTERNAL_TEST_INSTR &&
    instr != IDENT_INSTR |-> dr_sel == DR_BYPASS)
    else $error("undefined code not routed as bypass");
  a_sel_capture: assert property (
    cap_dr && dr_sel == DR_CHAIN_SEL |=> sel_shift == 4'h8)
    else $error("select register capture wrong");
  a_chain_update: assert property (
    upd_dr && dr_sel == DR_CHAIN_SEL |=> chain == $past(sel_shift))
    else $error("chain not taken from select register");
  a_chain_hold: assert property (
    trst_n && !(upd_dr && dr_sel == DR_CHAIN_SEL) |=> $stable(chain))
    else $error("chain changed without update");
  a_ident_capture: assert property (
    cap_dr && dr_sel == DR_IDENT ##1 state == ST_SHIFT_DR |=> serial_out_o == IDENT_CODE[0])
    else $error("identification lsb not shifted out");
  a_bypass_first_zero: assert property (
    cap_dr && dr_sel == DR_BYPASS ##1 state == ST_SHIFT_DR |=> !serial_out_o)
    else $error("bypass first bit not zero");
  a_ir_capture_lsb: assert property (
    en && trst_n && state == ST_CAP_IR |=> ir_shift == 4'h1)
    else $error("instruction capture value wrong");
  a_restart_pulse: assert property (
    en && trst_n && state == ST_UPD_IR && ir_shift == DEBUG_RESUME_INSTR && !tms
    |=> debug_restart_o ##1 !debug_restart_o)
    else $error("debug resume pulse missing");

endmodule

`default_nettype wire

// ### hdl/tap_pkg.sv
// Purpose: shared constants and types for the debug test access port controller
// Assumes: one 100 MHz core clock; all port pins sampled on that clock
// Notes: instruction codes, capture constants and state encodings live here

package tap_pkg;

  // ---------------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------------
  localparam int IR_W = 4;         // instruction register length
  localparam int SEL_W = 4;        // scan path select register length
  localparam int ID_W = 32;        // identification register length
  localparam int SYNC_W = 4;       // number of synchronised pins

  // ---------------------------------------------------------------------------
  // instruction codes
  // ---------------------------------------------------------------------------
  localparam logic [IR_W-1:0] CHAIN_SELECT_INSTR = 4'h2;   // route scan path select register
  localparam logic [IR_W-1:0] INTERNAL_TEST_INSTR = 4'hc;  // selected chain, cells in test mode
  localparam logic [IR_W-1:0] IDENT_INSTR = 4'he;          // identification register
  localparam logic [IR_W-1:0] BYPASS_INSTR = 4'hf;         // one-bit bypass register
  localparam logic [IR_W-1:0] DEBUG_RESUME_INSTR = 4'h4;   // bypass plus leave debug state

  // ---------------------------------------------------------------------------
  // capture and reset values
  // ---------------------------------------------------------------------------
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;       // loaded in capture-ir
  localparam logic [SEL_W-1:0] SEL_CAPTURE_VAL = 4'h8;     // loaded in capture-dr
  localparam logic [SEL_W-1:0] CHAIN_RESET_VAL = 4'h0;     // chain active after reset

  // ---------------------------------------------------------------------------
  // implemented chain numbers; everything else is reserved
  // ---------------------------------------------------------------------------
  localparam logic [SEL_W-1:0] CHAIN_USER = 4'h0;
  localparam logic [SEL_W-1:0] CHAIN_DEBUG = 4'h1;
  localparam logic [SEL_W-1:0] CHAIN_ICE = 4'h2;
  localparam logic [SEL_W-1:0] CHAIN_SYSCTL = 4'hf;
  localparam int CHAIN_CNT = 4;    // returns of chains user, debug, ice, sysctl

  // ---------------------------------------------------------------------------
  // synchronised pin positions
  // ---------------------------------------------------------------------------
  localparam int PIN_MODE = 0;
  localparam int PIN_DATA = 1;
  localparam int PIN_ENABLE = 2;
  localparam int PIN_TRST = 3;
  localparam logic [SYNC_W-1:0] PIN_RESET_VAL = 4'h0;   // test reset held active at start

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  // gray codes along the dr then ir path
  typedef enum logic [3:0] {
    ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h3, ST_CAP_DR = 4'h2,
    ST_SHIFT_DR = 4'h6, ST_EXIT1_DR = 4'h7, ST_PAUSE_DR = 4'h5, ST_EXIT2_DR = 4'h4,
    ST_UPD_DR = 4'hc, ST_SEL_IR = 4'hd, ST_CAP_IR = 4'hf, ST_SHIFT_IR = 4'he,
    ST_EXIT1_IR = 4'ha, ST_PAUSE_IR = 4'hb, ST_EXIT2_IR = 4'h9, ST_UPD_IR = 4'h8
  } tap_state_e;

  // data register placed on the serial path
  typedef enum logic [1:0] {
    DR_BYPASS = 2'h0, DR_IDENT = 2'h1, DR_CHAIN_SEL = 2'h2, DR_INTERNAL = 2'h3
  } dr_path_e;

  // control bundle toward the external scan chains
  typedef struct packed {
    logic [SEL_W-1:0] chain;   // active chain number
    logic test_mode;           // cells intercept signals
    logic capture;             // one-cycle capture strobe
    logic shift;               // one-cycle shift strobe
    logic update;              // one-cycle update strobe
    logic serial_data;         // serial bit into the chain
  } scan_ctrl_s;

endpackage

// ### sim/tap_host.sv
// Purpose: debugger side of the test port, steps the state graph and scans registers
// Assumes: every pin is held steady long enough for the pin filter to pass it
// Notes: each enable window is two steps or more, with quiet gaps around it

`timescale 1ns/1ns
`default_nettype none

module tap_host (
  input wire logic core_clk_i,
  input wire logic serial_out_i,
  output logic mode_select_o,
  output logic serial_data_o,
  output logic enable_o,
  output logic test_reset_n_o
);
  // --------------------------------------------------------------
  // pin drive
  // --------------------------------------------------------------
  localparam int GAP = 8;  // quiet cycles, longer than the pin latency

  // pins idle, test reset active from power-up
  initial begin
    mode_select_o = 1'b1;
    serial_data_o = 1'b0;
    enable_o = 1'b0;
    test_reset_n_o = 1'b0;
  end

  // reset pulse first
  // test reset driven low, then high again before the port is used
  task automatic pulse_reset();
    test_reset_n_o = 1'b0;
    repeat (GAP) @(negedge core_clk_i);
    test_reset_n_o = 1'b1;
    repeat (GAP) @(negedge core_clk_i);
  endtask

  // graph-driven steps
  // one enable window of n steps; mode select bit i applies to step i
  task automatic win(input int n, input logic [3:0] pat, input logic tdi);
    integer i;
    @(negedge core_clk_i);
    mode_select_o = pat[0];
    serial_data_o = tdi;
    repeat (GAP) @(negedge core_clk_i);
    for (i = 0; i < n; i++) begin
      mode_select_o = pat[i];
      enable_o = 1'b1;
      @(negedge core_clk_i);
    end
    enable_o = 1'b0;
    repeat (GAP) @(negedge core_clk_i);
  endtask

  // pins wander while the enable stays low; nothing may step
  task automatic noise();
    mode_select_o = 1'b1;
    serial_data_o = 1'b1;
    repeat (4 * GAP) @(negedge core_clk_i);
    mode_select_o = 1'b0;
    repeat (GAP) @(negedge core_clk_i);
  endtask

  // scan via pause loop
  // scan n bits from idle through ir or dr, one bit per shift-exit-pause trip
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    integer i;
    dout = '0;
    if (ir) begin
      win(4, 4'b0011, 1'b0);  // select dr, select ir, capture, shift
    end else begin
      win(3, 4'b0001, 1'b0);  // select dr, capture, shift
    end
    for (i = 0; i < n; i++) begin
      dout[i] = serial_out_i;
      win(2, 4'b0001, din[i]);  // shift one bit, exit1, pause
      if (i < n - 1) begin
        win(2, 4'b0001, 1'b0);  // exit2, back to shift
      end else begin
        win(3, 4'b0011, 1'b0);  // exit2, update, idle
      end
    end
  endtask
endmodule

`default_nettype wire

// ### sim/testbench.sv
// Purpose: self-checking bench for the debug test access port controller
// Assumes: the host model steps the port; chain one is a small bench register
// Notes: registers are read back lsb first as the host scans them

`timescale 1ns/1ns
`default_nettype none

module testbench;
  import tap_pkg::*;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  localparam logic [ID_W-1:0] ID_VAL = 32'h5a3c_9617;  // arbitrary value
  localparam logic [7:0] CAP1 = 8'hc9;  // what chain one captures
  logic core_clk, resetn, tms, tdi, en, trst_n, tdo, restart;
  logic [CHAIN_CNT-1:0] chain_ret;
  scan_ctrl_s scan;
  logic [7:0] chain1 = 8'h00;  // bench model of chain one
  int num_errors = 0;
  int cmp_count = 0;
  int restarts = 0;
  int updates = 0;  // update strobes seen by the chains
  int cycles = 0;
  logic [31:0] got;

  debug_tap_controller #(.IDENT_CODE(ID_VAL)) uut (
    .core_clk_i(core_clk), .resetn_i(resetn), .mode_select_in_i(tms),
    .serial_in_i(tdi), .tap_clock_enable_i(en), .test_reset_n_i(trst_n),
    .chain_return_i(chain_ret), .serial_out_o(tdo), .scan_o(scan),
    .debug_restart_o(restart)
  );

  tap_host host (
    .core_clk_i(core_clk), .serial_out_i(tdo), .mode_select_o(tms),
    .serial_data_o(tdi), .enable_o(en), .test_reset_n_o(trst_n)
  );

  // --------------------------------------------------------------
  // clock, chain model, monitors
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // chain one captures and shifts only while cells are in test mode
  always @(posedge core_clk) begin
    if (scan.test_mode && scan.chain == CHAIN_DEBUG) begin
      if (scan.capture) begin
        chain1 <= CAP1;
      end else if (scan.shift) begin
        chain1 <= {scan.serial_data, chain1[7:1]};
      end
    end
  end
  // other implemented chains return ones, so a reserved chain stands out
  assign chain_ret = {1'b1, 1'b1, chain1[0], 1'b1};

  // count restart pulses and cut a hang short
  always @(posedge core_clk) begin
    if (restart === 1'b1) begin
      restarts++;
    end
    if (scan.update === 1'b1) begin
      updates++;
    end
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      test_done();
    end
  end

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic load_ir(input logic [3:0] code);
    host.scan(1'b1, 4, 32'(code), got);
    check(got, 32'(IR_CAPTURE_VAL));
  endtask

  task automatic select_chain(input logic [3:0] num);
    load_ir(CHAIN_SELECT_INSTR);
    host.scan(1'b0, 4, 32'(num), got);
    check(got, 32'(SEL_CAPTURE_VAL));
    check(32'(scan.chain), 32'(num));
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_ident();
    check(32'(scan.chain), 32'(CHAIN_RESET_VAL));
    check(32'(scan.test_mode), 32'h0);
    host.scan(1'b0, 32, 32'hffff_0000, got);
    check(got, ID_VAL);
    host.scan(1'b0, 32, 32'h0, got);
    check(got, ID_VAL);
    check(32'(scan.test_mode), 32'h0);
    $display("test ident done");
  endtask

  task automatic t_enable();
    host.noise();
    host.scan(1'b0, 32, 32'h0, got);
    check(got, ID_VAL);
    $display("test enable done");
  endtask

  task automatic t_chains();
    logic [3:0] nums [4] = '{4'h5, CHAIN_SYSCTL, CHAIN_USER, CHAIN_ICE};
    logic [3:0] outs [4] = '{4'h0, 4'hf, 4'hf, 4'hf};
    integer i;
    int n0;
    select_chain(CHAIN_DEBUG);
    load_ir(INTERNAL_TEST_INSTR);
    check(32'(scan.test_mode), 32'h1);
    n0 = updates;
    host.scan(1'b0, 8, 32'h3c, got);
    check(got, 32'(CAP1));
    check(32'(chain1), 32'h3c);
    check(32'(updates - n0), 32'h1);
    check(32'(scan.chain), 32'(CHAIN_DEBUG));
    // reserved chain shifts zeros, implemented ones their returns
    for (i = 0; i < 4; i++) begin
      select_chain(nums[i]);
      load_ir(INTERNAL_TEST_INSTR);
      host.scan(1'b0, 4, 32'h0, got);
      check(got, 32'(outs[i]));
    end
    $display("test chains done");
  endtask

  task automatic t_trst();
    host.pulse_reset();
    check(32'(scan.test_mode), 32'h0);
    check(32'(scan.chain), 32'(CHAIN_RESET_VAL));
    host.win(2, 4'b0000, 1'b0);
    host.scan(1'b0, 32, 32'h0, got);
    check(got, ID_VAL);
    $display("test test reset done");
  endtask

  // bypass, resume and unused codes all give a one-bit path that captures zero
  task automatic t_bypass();
    logic [3:0] codes [5] = '{BYPASS_INSTR, DEBUG_RESUME_INSTR, 4'h7, 4'h0, 4'ha};
    integer i;
    int n0;
    int n1;
    for (i = 0; i < 5; i++) begin
      // resume pulses once as it is loaded and once as the scan returns to idle
      n0 = restarts;
      load_ir(codes[i]);
      n1 = updates;
      host.scan(1'b0, 8, 32'hb5, got);
      check(got, 32'h6a);
      check(32'(scan.test_mode), 32'h0);
      check(32'(scan.chain), 32'(CHAIN_RESET_VAL));
      check(32'(updates - n1), 32'h0);
      check(32'(restarts - n0), (codes[i] == DEBUG_RESUME_INSTR) ? 32'h2 : 32'h0);
    end
    $display("test bypass done");
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    host.pulse_reset();
    host.win(2, 4'b0000, 1'b0);
    t_ident();
    t_enable();
    t_chains();
    t_trst();
    t_bypass();
    test_done();
  end
endmodule

`default_nettype wire
